// *** logic/tsq_params.svh ***
// constants of the trigger sequencer: offsets, codes, limits, timing
// assumes inclusion by the sequencer module and the bench
`ifndef TSQ_PARAMS_SVH
`define TSQ_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TSQ_ADDR_CMD     8'h00
`define TSQ_ADDR_SRC     8'h04
`define TSQ_ADDR_TIMER   8'h08
`define TSQ_ADDR_DELAY   8'h0c
`define TSQ_ADDR_TCOUNT  8'h10
`define TSQ_ADDR_SCOUNT  8'h14
`define TSQ_ADDR_CONFIG  8'h18
`define TSQ_ADDR_HOLD    8'h1c
`define TSQ_ADDR_STATUS  8'h20
`define TSQ_ADDR_ERROR   8'h24
// ----------------------------------------
// command codes, written to the command register
// ----------------------------------------
`define TSQ_CMD_ABORT    8'h01
`define TSQ_CMD_INIT     8'h02
`define TSQ_CMD_CONT_ON  8'h03
`define TSQ_CMD_CONT_OFF 8'h04
`define TSQ_CMD_PRESET   8'h05
`define TSQ_CMD_RESET    8'h06
`define TSQ_CMD_RECALL   8'h07
`define TSQ_CMD_SAVE     8'h08
`define TSQ_CMD_BUS_TRIG 8'h09
`define TSQ_CMD_SIGNAL   8'h0a
`define TSQ_CMD_READ     8'h0b
`define TSQ_CMD_FETCH    8'h0c
`define TSQ_SLOT_LAST    2'h2
// ----------------------------------------
// control source codes
// ----------------------------------------
`define TSQ_SRC_IMM      3'h0
`define TSQ_SRC_TIMER    3'h1
`define TSQ_SRC_MAN      3'h2
`define TSQ_SRC_BUS      3'h3
`define TSQ_SRC_EXT      3'h4
// ----------------------------------------
// field positions and limits
// ----------------------------------------
`define TSQ_CFG_AUTODLY  0
`define TSQ_CFG_SCAN     1
`define TSQ_CFG_REMOTE   2
`define TSQ_STS_ERR      2
`define TSQ_COUNT_INF    16'h0000
`define TSQ_COUNT_ONE    16'h0001
`define TSQ_COUNT_MAX    16'hd6d8
`define TSQ_TIME_MAX_MS  30'h3b9ac9ff
`define TSQ_TIMER_DEF_MS 30'h0000064
`define TSQ_DELAY_DEF_MS 30'h0000000
`define TSQ_TICK_NS      1000000
`define TSQ_CLK_NS       8
// ----------------------------------------
// error codes; all but the conflict code are arbitrary
// ----------------------------------------
`define TSQ_ERR_NONE     16'h0000
`define TSQ_ERR_CONFLICT 16'hff23
`define TSQ_ERR_INIT     16'hff01
`define TSQ_ERR_SIGNAL   16'hff02
`define TSQ_ERR_CONT     16'hff03
`define TSQ_ERR_RANGE    16'hff04
`endif

// *** logic/tsq_pkg.sv ***
// types of the trigger sequencer
// assumes nothing beyond the sequencer itself
package tsq_pkg;
   // sequencer flow states
   typedef enum logic [2:0] {IDLE, START, WAIT_SRC, DELAY, ACTION, OUT_TRIG} tsq_state_t;
endpackage

// *** logic/tsq_trigger_sequencer.sv ***
// trigger sequencer: apb registers, trigger flow, counters, link pulses
// assumes apb master on clk, inputs synchronous to clk
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "tsq_params.svh"

module tsq_trigger_sequencer #(
   parameter int MS_CYCLES = `TSQ_TICK_NS / `TSQ_CLK_NS   // clocks per ms
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extTrigIn,
   input  wire logic        interlockIn,
   input  wire logic        trigKeyPress,
   input  wire logic        measureDone,
   output logic             measureStart,
   output logic             closeNextChannel,
   output logic             bufWrite,
   output logic      [15:0] bufAddr,
   output logic             readingsFetch,
   output logic             measurement_complete_output
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   tsq_pkg::tsq_state_t state_r;          // flow state
   logic [2:0]  src_r;                    // control source
   logic [29:0] timer_r;                  // timer interval, ms
   logic [29:0] delay_r;                  // delay, ms
   logic [15:0] trigCnt_r;                // trigger count, 0 infinite
   logic [15:0] sampCnt_r;                // sample count
   logic        cont_r;                   // continuous initiation
   logic        autoDly_r;                // auto delay enable
   logic        scan_r;                   // internal scanner enable
   logic        remote_r;                 // remote mode
   logic [15:0] hold_r;                   // hold settings word
   logic        slotCont_r [3];           // saved setups
   logic [2:0]  slotSrc_r  [3];
   logic [15:0] slotTrig_r [3];
   logic [15:0] slotSamp_r [3];
   logic        errFlag_r;                // sticky error
   logic [15:0] errCode_r;                // last error code
   logic        oneShot_r;                // single cycle requested
   logic        fetchPend_r;              // read awaits completion
   logic        firstPass_r;              // timer bypass pass
   logic [15:0] trigLeft_r;               // trigger loops left
   logic [15:0] sampLeft_r;               // samples left
   logic [15:0] bufIndex_r;               // next buffer position
   logic [29:0] dlyLeft_r;                // ms left in delay
   logic [31:0] tickCnt_r;                // ms divider
   logic        extPrev_r;                // last external level
   logic        errNow;                   // error this cycle
   logic [15:0] errCodeNow;               // its code
   logic        addrHit;                  // mapped address

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic        setupPh;
   logic        wrEn;
   logic [7:0]  cmdCode;
   logic [1:0]  cmdSlot;
   logic        cmdWr;
   assign setupPh = psel & ~penable;
   assign wrEn    = psel & penable & pwrite;
   assign cmdWr   = wrEn & (paddr == `TSQ_ADDR_CMD);
   assign cmdCode = pwdata[7:0];
   assign cmdSlot = pwdata[9:8];
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrHit;

   // map of valid offsets
   always_comb begin
      case (paddr)
         `TSQ_ADDR_CMD, `TSQ_ADDR_SRC, `TSQ_ADDR_TIMER, `TSQ_ADDR_DELAY,
         `TSQ_ADDR_TCOUNT, `TSQ_ADDR_SCOUNT, `TSQ_ADDR_CONFIG,
         `TSQ_ADDR_HOLD, `TSQ_ADDR_STATUS, `TSQ_ADDR_ERROR: addrHit = 1'b1;
         default: addrHit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // command strobes
   // ----------------------------------------
   logic isAbort, isInit, isContOn, isContOff, isPreset, isReset;
   logic isRecall, isSave, isBusTrig, isSignal, isRead, isFetch;
   logic slotOk, readOk, contOnOk, goTop, atIdle, waitSrc;
   assign slotOk    = cmdSlot <= `TSQ_SLOT_LAST;
   assign isAbort   = cmdWr & (cmdCode == `TSQ_CMD_ABORT);
   assign isInit    = cmdWr & (cmdCode == `TSQ_CMD_INIT);
   assign isContOn  = cmdWr & (cmdCode == `TSQ_CMD_CONT_ON);
   assign isContOff = cmdWr & (cmdCode == `TSQ_CMD_CONT_OFF);
   assign isPreset  = cmdWr & (cmdCode == `TSQ_CMD_PRESET);
   assign isReset   = cmdWr & (cmdCode == `TSQ_CMD_RESET);
   assign isRecall  = cmdWr & (cmdCode == `TSQ_CMD_RECALL) & slotOk;
   assign isSave    = cmdWr & (cmdCode == `TSQ_CMD_SAVE) & slotOk;
   assign isBusTrig = cmdWr & (cmdCode == `TSQ_CMD_BUS_TRIG);
   assign isSignal  = cmdWr & (cmdCode == `TSQ_CMD_SIGNAL);
   assign isRead    = cmdWr & (cmdCode == `TSQ_CMD_READ);
   assign isFetch   = cmdWr & (cmdCode == `TSQ_CMD_FETCH);
   assign atIdle    = state_r == tsq_pkg::IDLE;
   assign waitSrc   = state_r == tsq_pkg::WAIT_SRC;
   assign readOk    = isRead & ~cont_r;
   assign contOnOk  = isContOn & (sampCnt_r <= `TSQ_COUNT_ONE);
   assign goTop     = isAbort | isRecall | isPreset | isReset | readOk;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   logic wrSrc, wrTimer, wrDelay, wrTcount, wrScount, wrConfig, wrHold, wrStatus;
   logic srcOk, timerOk, delayOk, tcountOk, scountOk;
   assign wrSrc    = wrEn & (paddr == `TSQ_ADDR_SRC);
   assign wrTimer  = wrEn & (paddr == `TSQ_ADDR_TIMER);
   assign wrDelay  = wrEn & (paddr == `TSQ_ADDR_DELAY);
   assign wrTcount = wrEn & (paddr == `TSQ_ADDR_TCOUNT);
   assign wrScount = wrEn & (paddr == `TSQ_ADDR_SCOUNT);
   assign wrConfig = wrEn & (paddr == `TSQ_ADDR_CONFIG);
   assign wrHold   = wrEn & (paddr == `TSQ_ADDR_HOLD);
   assign wrStatus = wrEn & (paddr == `TSQ_ADDR_STATUS);
   assign srcOk    = pwdata <= {29'h0, `TSQ_SRC_EXT};
   assign timerOk  = pwdata <= {2'h0, `TSQ_TIME_MAX_MS};
   assign delayOk  = pwdata <= {2'h0, `TSQ_TIME_MAX_MS};
   assign tcountOk = pwdata <= {16'h0, `TSQ_COUNT_MAX};
   assign scountOk = (pwdata >= {16'h0, `TSQ_COUNT_ONE}) & (pwdata <= {16'h0, `TSQ_COUNT_MAX});

   // error detection, first cause wins
   always_comb begin
      errNow     = 1'b1;
      errCodeNow = `TSQ_ERR_NONE;
      if (isInit & ~atIdle) errCodeNow = `TSQ_ERR_INIT;
      else if (isSignal & ~waitSrc) errCodeNow = `TSQ_ERR_SIGNAL;
      else if (isRead & cont_r) errCodeNow = `TSQ_ERR_CONT;
      else if (isContOn & ~contOnOk) errCodeNow = `TSQ_ERR_CONT;
      else if (wrScount & scountOk & cont_r & (pwdata[15:0] > `TSQ_COUNT_ONE))
         errCodeNow = `TSQ_ERR_CONT;
      else if (wrHold & scan_r) errCodeNow = `TSQ_ERR_CONFLICT;
      else if ((wrSrc & ~srcOk) | (wrTimer & ~timerOk) | (wrDelay & ~delayOk)
               | (wrTcount & ~tcountOk) | (wrScount & ~scountOk))
         errCodeNow = `TSQ_ERR_RANGE;
      else if (cmdWr & ~(isAbort | isInit | isContOn | isContOff | isPreset | isReset
               | isRecall | isSave | isBusTrig | isSignal | isRead | isFetch))
         errCodeNow = `TSQ_ERR_RANGE;
      else errNow = 1'b0;
   end

   // sticky error flag, a new error beats the clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         errFlag_r <= 1'b0;
         errCode_r <= `TSQ_ERR_NONE;
      end else begin
         if (errNow) begin
            errFlag_r <= 1'b1;
            errCode_r <= errCodeNow;
         end else if (wrStatus & pwdata[`TSQ_STS_ERR]) begin
            errFlag_r <= 1'b0;
         end
      end
   end

   // settings registers
   always_ff @(posedge clk) begin
      if (!reset_n || isReset) begin
         src_r     <= `TSQ_SRC_IMM;
         timer_r   <= `TSQ_TIMER_DEF_MS;
         delay_r   <= `TSQ_DELAY_DEF_MS;
         trigCnt_r <= `TSQ_COUNT_ONE;
         sampCnt_r <= `TSQ_COUNT_ONE;
         cont_r    <= 1'b0;
         hold_r    <= 16'h0000;
         autoDly_r <= 1'b0;
         scan_r    <= 1'b0;
         remote_r  <= 1'b0;
      end else if (isPreset) begin
         cont_r    <= 1'b1;
         trigCnt_r <= `TSQ_COUNT_INF;
         sampCnt_r <= `TSQ_COUNT_ONE;
      end else if (isRecall) begin
         cont_r    <= slotCont_r[cmdSlot];
         src_r     <= slotSrc_r[cmdSlot];
         trigCnt_r <= slotTrig_r[cmdSlot];
         sampCnt_r <= slotSamp_r[cmdSlot];
      end else begin
         if (contOnOk) cont_r <= 1'b1;
         if (isContOff) cont_r <= 1'b0;
         if (wrSrc & srcOk) src_r <= pwdata[2:0];
         if (wrTimer & timerOk) timer_r <= pwdata[29:0];
         if (wrDelay & delayOk) delay_r <= pwdata[29:0];
         if (wrTcount & tcountOk) trigCnt_r <= pwdata[15:0];
         if (wrScount & scountOk & ~(cont_r & (pwdata[15:0] > `TSQ_COUNT_ONE)))
            sampCnt_r <= pwdata[15:0];
         if (wrHold & ~scan_r) hold_r <= pwdata[15:0];
         if (wrConfig) begin
            autoDly_r <= pwdata[`TSQ_CFG_AUTODLY];
            scan_r    <= pwdata[`TSQ_CFG_SCAN];
            remote_r  <= pwdata[`TSQ_CFG_REMOTE];
            if (!pwdata[`TSQ_CFG_AUTODLY]) delay_r <= `TSQ_DELAY_DEF_MS;
         end
      end
   end

   // stored setup slots
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         if (!reset_n) begin
            slotCont_r[i] <= 1'b0;
            slotSrc_r[i]  <= `TSQ_SRC_IMM;
            slotTrig_r[i] <= `TSQ_COUNT_ONE;
            slotSamp_r[i] <= `TSQ_COUNT_ONE;
         end else if (isSave && cmdSlot == 2'(i)) begin
            slotCont_r[i] <= cont_r;
            slotSrc_r[i]  <= src_r;
            slotTrig_r[i] <= trigCnt_r;
            slotSamp_r[i] <= sampCnt_r;
         end
      end
   end

   // ----------------------------------------
   // control source events
   // ----------------------------------------
   logic extFall, srcEvent, release_, moreSamp, moreTrig, dlyLoad, tick;
   assign extFall = extPrev_r & ~extTrigIn;

   // last level of the external trigger line
   always_ff @(posedge clk) begin
      if (!reset_n) extPrev_r <= 1'b1;
      else extPrev_r <= extTrigIn;
   end

   // event of the selected source
   always_comb begin
      case (src_r)
         `TSQ_SRC_IMM:   srcEvent = 1'b1;
         `TSQ_SRC_TIMER: srcEvent = 1'b1;
         `TSQ_SRC_MAN:   srcEvent = trigKeyPress & ~remote_r;
         `TSQ_SRC_BUS:   srcEvent = isBusTrig;
         `TSQ_SRC_EXT:   srcEvent = extFall & interlockIn;
         default:        srcEvent = 1'b0;
      endcase
   end

   assign release_ = waitSrc & (srcEvent | isSignal);
   assign moreSamp = sampLeft_r > `TSQ_COUNT_ONE;
   assign moreTrig = (trigCnt_r == `TSQ_COUNT_INF) | (trigLeft_r > `TSQ_COUNT_ONE);
   assign dlyLoad  = release_ | (state_r == tsq_pkg::ACTION & measureDone & moreSamp);
   assign tick     = tickCnt_r == 32'(MS_CYCLES - 1);

   // ----------------------------------------
   // flow state machine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) state_r <= tsq_pkg::IDLE;
      // abort goes to start, which decides
      else if (goTop) state_r <= tsq_pkg::START;
      else begin
         case (state_r)
            tsq_pkg::IDLE:
               if (isInit | (contOnOk & ~cont_r)) state_r <= tsq_pkg::START;
            tsq_pkg::START:
               state_r <= (cont_r | oneShot_r) ? tsq_pkg::WAIT_SRC : tsq_pkg::IDLE;
            tsq_pkg::WAIT_SRC:
               if (release_) state_r <= tsq_pkg::DELAY;
            tsq_pkg::DELAY:
               if (dlyLeft_r == `TSQ_DELAY_DEF_MS) state_r <= tsq_pkg::ACTION;
            tsq_pkg::ACTION:
               if (measureDone) state_r <= moreSamp ? tsq_pkg::DELAY : tsq_pkg::OUT_TRIG;
            tsq_pkg::OUT_TRIG:
               state_r <= moreTrig ? tsq_pkg::WAIT_SRC : tsq_pkg::START;
            default: state_r <= tsq_pkg::IDLE;
         endcase
      end
   end

   // single cycle and pending fetch flags
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         oneShot_r   <= 1'b0;
         fetchPend_r <= 1'b0;
      end else if (goTop) begin
         oneShot_r   <= readOk;
         fetchPend_r <= readOk;
      end else begin
         if (atIdle & isInit) oneShot_r <= 1'b1;
         else if (state_r == tsq_pkg::START) oneShot_r <= 1'b0;
         if (state_r == tsq_pkg::OUT_TRIG & ~moreTrig) fetchPend_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // counters and timing
   // ----------------------------------------
   // millisecond divider, realigned at each delay load
   always_ff @(posedge clk) begin
      if (!reset_n || dlyLoad || tick) tickCnt_r <= 32'h0;
      else tickCnt_r <= tickCnt_r + 32'h1;
   end

   // loop counters, buffer position and delay
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         firstPass_r <= 1'b1;
         trigLeft_r  <= `TSQ_COUNT_ONE;
         sampLeft_r  <= `TSQ_COUNT_ONE;
         bufIndex_r  <= 16'h0000;
         dlyLeft_r   <= `TSQ_DELAY_DEF_MS;
      end else if (state_r == tsq_pkg::START) begin
         firstPass_r <= 1'b1;
         trigLeft_r  <= trigCnt_r;
         sampLeft_r  <= sampCnt_r;
         bufIndex_r  <= 16'h0000;
      end else if (release_) begin
         firstPass_r <= 1'b0;
         if (src_r == `TSQ_SRC_TIMER && !firstPass_r && timer_r > delay_r)
            dlyLeft_r <= timer_r;
         else
            dlyLeft_r <= delay_r;
      end else if (state_r == tsq_pkg::DELAY) begin
         if (tick && dlyLeft_r != `TSQ_DELAY_DEF_MS) dlyLeft_r <= dlyLeft_r - 30'h1;
      end else if (state_r == tsq_pkg::ACTION) begin
         if (measureDone) begin
            bufIndex_r <= bufIndex_r + 16'h1;
            if (moreSamp) begin
               sampLeft_r <= sampLeft_r - 16'h1;
               dlyLeft_r  <= delay_r;
            end
         end
      end else if (state_r == tsq_pkg::OUT_TRIG && moreTrig) begin
         // next loop overwrites from the start
         bufIndex_r <= 16'h0000;
         sampLeft_r <= sampCnt_r;
         if (trigCnt_r != `TSQ_COUNT_INF) trigLeft_r <= trigLeft_r - 16'h1;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         measureStart                <= 1'b0;
         closeNextChannel            <= 1'b0;
         bufWrite                    <= 1'b0;
         bufAddr                     <= 16'h0000;
         readingsFetch               <= 1'b0;
         measurement_complete_output <= 1'b0;
      end else begin
         measureStart     <= ~goTop & (state_r == tsq_pkg::DELAY) & (dlyLeft_r == `TSQ_DELAY_DEF_MS);
         closeNextChannel <= ~goTop & (state_r == tsq_pkg::DELAY) & (dlyLeft_r == `TSQ_DELAY_DEF_MS) & scan_r;
         bufWrite <= (state_r == tsq_pkg::ACTION) & measureDone & (sampCnt_r > `TSQ_COUNT_ONE);
         if ((state_r == tsq_pkg::ACTION) & measureDone) bufAddr <= bufIndex_r;
         readingsFetch <= isFetch | (fetchPend_r & ~goTop & (state_r == tsq_pkg::OUT_TRIG) & ~moreTrig);
         // pulse at end of sample series
         measurement_complete_output <= ~goTop & (state_r == tsq_pkg::OUT_TRIG);
      end
   end

   // read data, taken in the setup phase
   always_ff @(posedge clk) begin
      if (!reset_n) prdata <= 32'h0;
      else if (setupPh) begin
         case (paddr)
            `TSQ_ADDR_SRC:    prdata <= {29'h0, src_r};
            `TSQ_ADDR_TIMER:  prdata <= {2'h0, timer_r};
            `TSQ_ADDR_DELAY:  prdata <= {2'h0, delay_r};
            `TSQ_ADDR_TCOUNT: prdata <= {16'h0, trigCnt_r};
            `TSQ_ADDR_SCOUNT: prdata <= {16'h0, sampCnt_r};
            `TSQ_ADDR_CONFIG: prdata <= {29'h0, remote_r, scan_r, autoDly_r};
            `TSQ_ADDR_HOLD:   prdata <= {16'h0, hold_r};
            `TSQ_ADDR_STATUS: prdata <= {bufIndex_r, 11'h0, ~atIdle, waitSrc, errFlag_r, cont_r, atIdle};
            `TSQ_ADDR_ERROR:  prdata <= {16'h0, errCode_r};
            default:          prdata <= 32'h0;
         endcase
      end
   end

endmodule

// *** bench/tsq_seq_props.sv ***
// port checker of the trigger sequencer
// assumes binding onto tsq_trigger_sequencer
`timescale 1ns/1ps
module tsq_seq_props (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       measureDone,
   input wire logic       measureStart,
   input wire logic       closeNextChannel,
   input wire logic       bufWrite,
   input wire logic       readingsFetch,
   input wire logic       measurement_complete_output
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_bad_addr_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
      else $error("unmapped access without error");
   a_close_with_meas: assert property (closeNextChannel |-> measureStart)
      else $error("channel step outside measure");
   a_meas_one_cycle: assert property (measureStart |=> !measureStart)
      else $error("measure start too long");
   a_buf_after_done: assert property (bufWrite |-> $past(measureDone))
      else $error("buffer write without reading");
   a_buf_one_cycle: assert property (bufWrite |=> !bufWrite)
      else $error("buffer write too long");
   a_pulse_after_done: assert property (measurement_complete_output |-> $past(measureDone, 2))
      else $error("output pulse without reading");
   a_pulse_one_cycle: assert property (measurement_complete_output |=> !measurement_complete_output)
      else $error("output pulse too long");
   a_fetch_one_cycle: assert property (readingsFetch |=> !readingsFetch)
      else $error("fetch pulse too long");
endmodule
bind tsq_trigger_sequencer tsq_seq_props u_tsq_seq_props (.clk, .reset_n, .psel, .penable, .paddr, .pready,
   .pslverr, .measureDone, .measureStart, .closeNextChannel, .bufWrite, .readingsFetch,
   .measurement_complete_output);

// *** bench/tsq_far_model.sv ***
// measurement engine and external trigger instrument
// assumes slow and fire driven on clk
`timescale 1ns/1ps
module tsq_far_model (
   input  wire logic clk,
   input  wire logic measureStart,
   input  wire logic slow,
   input  wire logic fire,
   output logic      measureDone = 1'b0,
   output logic      extTrigIn = 1'b1
);
   int cnt = -1;
   // reading ends two or seven cycles after start
   always @(posedge clk) begin
      measureDone <= (cnt == 0);
      if (measureStart) cnt <= slow ? 6 : 1;
      else if (cnt >= 0) cnt <= cnt - 1;
   end
   always @(posedge clk) extTrigIn <= !fire;
endmodule

// *** bench/tb.sv ***
// self-checking bench of the trigger sequencer
// assumes the far-side model and the bound checker
`timescale 1ns/1ps
`include "tsq_params.svh"
module tb;
   logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic        interlockIn = 1, trigKeyPress = 0, slow = 0, fire = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] bufAddr;
   logic        pready, pslverr, extTrigIn, measureDone, measureStart, closeNextChannel;
   logic        bufWrite, readingsFetch, measurement_complete_output;
   int          nMismatch = 0, nChecks = 0, nMeas = 0, nBuf = 0, nVmc = 0, em = 0, ev = 0, s;
   int          seed = 32'h97d764c9;
   int          nFetch = 0, cyc = 0, t0 = 0, gap = 0, lastAddr = 0;
   localparam int MS = 4;                 // clocks per ms in simulation
   tsq_trigger_sequencer #(.MS_CYCLES(MS)) u_tsq_trigger_sequencer (.clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .extTrigIn, .interlockIn, .trigKeyPress, .measureDone,
      .measureStart, .closeNextChannel, .bufWrite, .bufAddr, .readingsFetch, .measurement_complete_output);
   tsq_far_model u_tsq_far_model (.clk, .measureStart, .slow, .fire, .measureDone, .extTrigIn);
   initial forever #4 clk = ~clk;
   // pulse counters
   always @(posedge clk) begin
      nMeas <= nMeas + measureStart;
      nBuf <= nBuf + bufWrite;
      nVmc <= nVmc + measurement_complete_output;
      nFetch <= nFetch + readingsFetch;
      cyc <= cyc + 1;
      if (measureStart) t0 <= cyc;
      if (measureStart) gap <= cyc - t0;
      if (bufWrite) lastAddr <= bufAddr;
   end
   // longer of timer and delay, in clocks
   function automatic int exp_wait(input int tmr, input int dly);
      return (tmr > dly ? tmr : dly) * MS;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
      if (nMismatch == 0 && nChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer, bounded wait for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      for (int k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
            // one idle edge, so no signal is assigned twice at one edge
            @(posedge clk);
            return;
         end
      end
      nMismatch++;
      end_sim;
   endtask
   // poll status until idle, bounded
   task automatic wait_idle;
      for (int k = 0; k < 200; k++) begin
         apb(0, `TSQ_ADDR_STATUS, 0);
         if (rd[0] === 1'b1 && rd[4] === 1'b0) return;
      end
      nMismatch++;
      end_sim;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      apb(0, `TSQ_ADDR_SRC, 0);
      chk(rd, `TSQ_SRC_IMM);
      apb(0, `TSQ_ADDR_TIMER, 0);
      chk(rd, `TSQ_TIMER_DEF_MS);
      apb(0, 8'h40, 0);
      chk(er, 1);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_SIGNAL);
      apb(0, `TSQ_ADDR_ERROR, 0);
      chk(rd, `TSQ_ERR_SIGNAL);
      apb(1, `TSQ_ADDR_CONFIG, 2);
      apb(1, `TSQ_ADDR_HOLD, 5);
      apb(0, `TSQ_ADDR_ERROR, 0);
      chk(rd, `TSQ_ERR_CONFLICT);
      chk(nMeas, 0);
      // random sample series, second initiate while running
      repeat (3) begin
         s = 2 + $unsigned($random(seed)) % 7;
         slow <= $random(seed);
         apb(1, `TSQ_ADDR_SCOUNT, s);
         apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
         apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
         wait_idle;
         em += s;
         ev += 1;
         chk(nMeas, em);
         chk(nBuf, em);
         chk(lastAddr, s - 1);
         chk(nVmc, ev);
      end
      apb(0, `TSQ_ADDR_ERROR, 0);
      chk(rd, `TSQ_ERR_INIT);
      // external source: early and blocked events dropped
      apb(1, `TSQ_ADDR_SCOUNT, 1);
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_EXT);
      fire <= 1;
      @(posedge clk) fire <= 0;
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
      interlockIn <= 0;
      fire <= 1;
      @(posedge clk) fire <= 0;
      apb(0, `TSQ_ADDR_STATUS, 0);
      apb(0, `TSQ_ADDR_STATUS, 0);
      chk(rd[3], 1);
      interlockIn <= 1;
      fire <= 1;
      @(posedge clk) fire <= 0;
      wait_idle;
      chk(nMeas, em + 1);
      // timer source: later passes wait the longer of timer and delay
      slow <= 0;
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_TIMER);
      apb(1, `TSQ_ADDR_TIMER, 3);
      apb(1, `TSQ_ADDR_DELAY, 1);
      apb(1, `TSQ_ADDR_TCOUNT, 3);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
      wait_idle;
      // a pass with no wait spans 7 cycles with the fast reading
      chk(gap, 7 + exp_wait(3, 1));
      apb(1, `TSQ_ADDR_TCOUNT, 1);
      // bus source waits for the bus trigger
      s = nMeas;
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_BUS);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
      apb(0, `TSQ_ADDR_STATUS, 0);
      chk(rd[3], 1);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_BUS_TRIG);
      wait_idle;
      chk(nMeas, s + 1);
      // manual key ignored in remote, taken in local
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_MAN);
      apb(1, `TSQ_ADDR_CONFIG, 6);
      apb(0, `TSQ_ADDR_DELAY, 0);
      chk(rd, 0);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_INIT);
      trigKeyPress <= 1;
      @(posedge clk) trigKeyPress <= 0;
      apb(0, `TSQ_ADDR_STATUS, 0);
      chk(rd[3], 1);
      apb(1, `TSQ_ADDR_CONFIG, 2);
      trigKeyPress <= 1;
      @(posedge clk) trigKeyPress <= 0;
      wait_idle;
      chk(nMeas, s + 2);
      // read query: one run, then a fetch
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_IMM);
      apb(1, `TSQ_ADDR_SCOUNT, 2);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_READ);
      wait_idle;
      chk(nFetch, 1);
      chk(nMeas, s + 4);
      chk(lastAddr, 1);
      // continuous refusals, abort restart, reset and preset
      apb(1, `TSQ_ADDR_SRC, `TSQ_SRC_IMM);
      apb(1, `TSQ_ADDR_SCOUNT, 3);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_CONT_ON);
      apb(0, `TSQ_ADDR_ERROR, 0);
      chk(rd, `TSQ_ERR_CONT);
      apb(1, `TSQ_ADDR_SCOUNT, 1);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_CONT_ON);
      apb(1, `TSQ_ADDR_STATUS, 4);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_READ);
      apb(0, `TSQ_ADDR_STATUS, 0);
      chk(rd[2], 1);
      apb(1, `TSQ_ADDR_SCOUNT, 3);
      apb(0, `TSQ_ADDR_SCOUNT, 0);
      chk(rd, 1);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_ABORT);
      s = nMeas;
      repeat (4) apb(0, `TSQ_ADDR_STATUS, 0);
      chk(nMeas > s, 1);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_RESET);
      wait_idle;
      apb(0, `TSQ_ADDR_TCOUNT, 0);
      chk(rd, `TSQ_COUNT_ONE);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_PRESET);
      apb(0, `TSQ_ADDR_TCOUNT, 0);
      chk(rd, `TSQ_COUNT_INF);
      // recall of slot 0 stops the continuous run
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_RECALL);
      wait_idle;
      apb(0, `TSQ_ADDR_TCOUNT, 0);
      chk(rd, `TSQ_COUNT_ONE);
      apb(1, `TSQ_ADDR_CMD, `TSQ_CMD_RESET);
      end_sim;
   end
endmodule
